// ---- hdl/alert_timer.sv ----
`include "status_out_defines.svh"
module alert_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic msTick,
  input wire logic callStart,
  input wire logic answered,
  input wire logic flash,
  input wire logic [7:0] delayMs,
  input wire logic [7:0] durMs,
  output logic alertOut,
  output logic alertBegin
);
  status_out_pkg::alert_state_type state_reg;
  logic [7:0] msCnt_reg;
  logic [7:0] phase_reg;
  logic flashOn_reg;

  ////////////////////////////////////////////////////////////////
  // wait unanswered for the delay, then alert for the duration
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= status_out_pkg::ALERT_IDLE;
      msCnt_reg <= 8'h00;
    end else if (answered) begin
      state_reg <= status_out_pkg::ALERT_IDLE;
    end else if (callStart) begin
      state_reg <= status_out_pkg::ALERT_WAIT;
      msCnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        status_out_pkg::ALERT_WAIT: begin
          if (msCnt_reg >= delayMs) begin
            state_reg <= status_out_pkg::ALERT_ON;
            msCnt_reg <= 8'h00;
          end else if (msTick) begin
            msCnt_reg <= msCnt_reg + 8'h01;
          end
        end
        status_out_pkg::ALERT_ON: begin
          // zero duration keeps alerting until answered
          if (durMs != 8'h00 && msCnt_reg >= durMs) begin
            state_reg <= status_out_pkg::ALERT_IDLE;
          end else if (msTick) begin
            msCnt_reg <= msCnt_reg + 8'h01;
          end
        end
        default: state_reg <= status_out_pkg::ALERT_IDLE;
      endcase
    end
  end

  // flash phase for pulsed mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 8'h00;
      flashOn_reg <= 1'b1;
    end else if (state_reg != status_out_pkg::ALERT_ON) begin
      phase_reg <= 8'h00;
      flashOn_reg <= 1'b1;
    end else if (msTick) begin
      if (phase_reg == 8'(`FLASH_MS - 1)) begin
        phase_reg <= 8'h00;
        flashOn_reg <= ~flashOn_reg;
      end else begin
        phase_reg <= phase_reg + 8'h01;
      end
    end
  end

  assign alertOut = (state_reg == status_out_pkg::ALERT_ON) && (flashOn_reg || !flash);
  assign alertBegin = (state_reg == status_out_pkg::ALERT_WAIT) && !answered && !callStart
                      && (msCnt_reg >= delayMs);

  property p_answerStops;
    @(posedge sys_clk) disable iff (rst) answered |=> !alertOut;
  endproperty
  a_answerStops: assert property (p_answerStops) else $error("alert kept after answer");
endmodule

// ---- hdl/programmable_status_outputs.sv ----
// Decided for this implementation: the APB slave port and the register offsets.
`include "status_out_defines.svh"
module programmable_status_outputs #(
  parameter int unsigned LOCK_CYC = `LOCK_FILTER_CYC,
  parameter int unsigned POWERUP_CYC = `POWERUP_CYC,
  parameter int unsigned TICK_CYC = `TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rssiDetect,
  input wire logic noiseDetect,
  input wire logic txActive,
  input wire logic rfInhibit,
  input wire logic synthLocked,
  input wire logic [7:0] pttSrc,
  input wire logic callStart,
  input wire logic [1:0] callKind,
  input wire logic [2:0] ctrlSet,
  input wire logic [2:0] ctrlClr,
  input wire logic fkeyPress,
  output logic rfOutEnable,
  output logic [3:0] lineOut,
  output logic [3:0] lineOe,
  output logic irq
);
  logic [3:0] ctrl_reg;
  logic [19:0] lines_reg;
  logic [7:0] pttMask_reg;
  logic [31:0] alertCfg_reg;
  logic [7:0] callMap_reg;
  logic [3:0] intStat_reg;
  logic [3:0] intMask_reg;
  logic busy_reg;
  logic tx_reg;
  logic lock_reg;
  logic pttRefl_reg;
  logic [2:0] ctrlSt_reg;
  logic fkey_reg;
  logic fkeyPrev_reg;
  logic ready_reg;
  logic [31:0] upCnt_reg;
  logic [31:0] unlockCnt_reg;
  logic [31:0] tickCnt_reg;
  logic msTick;
  logic [1:0] alertOn;
  logic [1:0] alertBegin;
  logic [1:0] alertPick;
  logic anyPtt;
  logic [15:0] sigVec;
  logic [3:0] events;
  logic wrEn;
  logic [31:0] rdValue;
  logic [3:0] lineOut_next;

  // pick the status bit named by a select code
  function automatic logic sigFor(input logic [3:0] sel, input logic [15:0] vec);
    sigFor = vec[sel];
  endfunction

  // true for an offset the slave decodes
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr[1:0] == 2'b00) && (addr <= `REG_INTMASK);
  endfunction

  ////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign wrEn = psel && penable && pwrite && isMapped(paddr);

  // read mux
  always_comb begin
    rdValue = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: rdValue[3:0] = ctrl_reg;
      `REG_LINES: rdValue[19:0] = lines_reg;
      `REG_PTTMASK: rdValue[7:0] = pttMask_reg;
      `REG_ALERTCFG: rdValue = alertCfg_reg;
      `REG_CALLMAP: rdValue[7:0] = callMap_reg;
      `REG_STATUS: rdValue[11:0] = {ready_reg, sigVec[10:0]};
      `REG_INTSTAT: rdValue[3:0] = intStat_reg;
      `REG_INTMASK: rdValue[3:0] = intMask_reg;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdValue;
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 4'(`CTRL_RST);
      lines_reg <= `LINES_RST;
      pttMask_reg <= 8'h00;
      alertCfg_reg <= 32'h0000_0000;
      callMap_reg <= 8'h00;
      intMask_reg <= 4'h0;
    end else if (wrEn) begin
      case (paddr)
        `REG_CTRL: ctrl_reg <= pwdata[3:0];
        `REG_LINES: lines_reg <= pwdata[19:0];
        `REG_PTTMASK: pttMask_reg <= pwdata[7:0];
        `REG_ALERTCFG: alertCfg_reg <= pwdata;
        `REG_CALLMAP: callMap_reg <= pwdata[7:0];
        `REG_INTMASK: intMask_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky event flags, write one to clear, set wins
  assign events = {alertBegin, lock_reg && !(synthLocked || unlockCnt_reg < LOCK_CYC - 1),
                   !busy_reg && (ctrl_reg[`CTRL_NOISE] ? noiseDetect : rssiDetect)};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intStat_reg <= 4'h0;
    end else begin
      intStat_reg <= (intStat_reg & ~((wrEn && paddr == `REG_INTSTAT) ? pwdata[3:0] : 4'h0))
                     | events;
    end
  end

  assign irq = |(intStat_reg & intMask_reg);

  ////////////////////////////////////////////////////////////////
  // power-up hold: lines stay released until control begins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      upCnt_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      if (upCnt_reg == POWERUP_CYC - 1) begin
        ready_reg <= 1'b1;
      end else begin
        upCnt_reg <= upCnt_reg + 32'h0000_0001;
      end
    end
  end

  // millisecond tick for the alert timers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tickCnt_reg <= 32'h0000_0000;
    end else if (tickCnt_reg == TICK_CYC - 1) begin
      tickCnt_reg <= 32'h0000_0000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
    end
  end
  assign msTick = (tickCnt_reg == TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // busy, transmit and reflected PTT status, one cycle latency
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      tx_reg <= 1'b0;
      pttRefl_reg <= 1'b0;
    end else begin
      busy_reg <= ctrl_reg[`CTRL_NOISE] ? noiseDetect : rssiDetect;
      tx_reg <= txActive;
      pttRefl_reg <= |(pttSrc & pttMask_reg);
    end
  end

  // inhibit gates only the RF stage
  assign rfOutEnable = txActive && !rfInhibit;

  ////////////////////////////////////////////////////////////////
  // lock filter: short unlocks during relock are swallowed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      unlockCnt_reg <= 32'h0000_0000;
      lock_reg <= 1'b0;
    end else if (synthLocked) begin
      unlockCnt_reg <= 32'h0000_0000;
      lock_reg <= 1'b1;
    end else if (unlockCnt_reg < LOCK_CYC - 1) begin
      unlockCnt_reg <= unlockCnt_reg + 32'h0000_0001;
    end else begin
      lock_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control status lines latch between set and clear calls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlSt_reg <= 3'b000;
    end else begin
      ctrlSt_reg <= (ctrlSt_reg & ~ctrlClr) | ctrlSet;
    end
  end

  // function key status: follow the key, or toggle per press
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fkey_reg <= 1'b0;
      fkeyPrev_reg <= 1'b0;
    end else begin
      fkeyPrev_reg <= fkeyPress;
      if (!ctrl_reg[`CTRL_FKLATCH]) begin
        fkey_reg <= fkeyPress;
      end else if (fkeyPress && !fkeyPrev_reg) begin
        fkey_reg <= ~fkey_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // external alerts, started per call kind, answered by any PTT
  assign anyPtt = |pttSrc;
  assign alertPick = callMap_reg[{callKind, 1'b0} +: 2];

  generate
    for (genvar a = 0; a < 2; a++) begin : g_alert
      alert_timer u_alert (
        .sys_clk(sys_clk),
        .rst(rst),
        .msTick(msTick),
        .callStart(callStart && alertPick[a]),
        .answered(anyPtt),
        .flash(ctrl_reg[`CTRL_FLASH1 + a]),
        .delayMs(alertCfg_reg[16 * a +: 8]),
        .durMs(alertCfg_reg[16 * a + 8 +: 8]),
        .alertOut(alertOn[a]),
        .alertBegin(alertBegin[a])
      );
    end
  endgenerate

  // status vector indexed by select code, code zero never active
  assign sigVec = {5'b00000, fkey_reg, ctrlSt_reg, alertOn, pttRefl_reg, lock_reg, tx_reg,
                   busy_reg, 1'b0};

  ////////////////////////////////////////////////////////////////
  // line drivers with per-line polarity
  generate
    for (genvar i = 0; i < `NUM_LINES; i++) begin : g_line
      // high polarity drives the signal, low drives its inverse
      assign lineOut_next[i] = !(sigFor(lines_reg[`LINE_W * i +: 4], sigVec)
                                 ^ lines_reg[`LINE_W * i + `LINE_POL]);
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lineOut <= 4'h0;
      lineOe <= 4'h0;
    end else begin
      lineOut <= lineOut_next;
      lineOe <= {4{ready_reg}};
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_unlockRun;
    !synthLocked [*8];
  endsequence

  property p_undriven;
    !ready_reg |=> lineOe == 4'h0;
  endproperty
  a_undriven: assert property (p_undriven) else $error("line driven before ready");

  property p_polarity;
    ##1 lineOe[0] |-> lineOut[0] ==
      !($past(sigVec[lines_reg[3:0]]) ^ $past(lines_reg[`LINE_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("line level wrong");

  property p_unused;
    (lines_reg[3:0] == `SIG_NONE) && $stable(lines_reg)
      |=> lineOut[0] == !$past(lines_reg[`LINE_POL]);
  endproperty
  a_unused: assert property (p_unused) else $error("unused line not inactive");

  property p_busy;
    ctrl_reg[`CTRL_NOISE] && $stable(ctrl_reg) |=> busy_reg == $past(noiseDetect);
  endproperty
  a_busy: assert property (p_busy) else $error("busy not following noise");

  property p_tx;
    txActive |=> tx_reg;
  endproperty
  a_tx: assert property (p_tx) else $error("tx status lost");

  property p_rfInhibit;
    rfInhibit |-> !rfOutEnable;
  endproperty
  a_rfInhibit: assert property (p_rfInhibit) else $error("rf not inhibited");

  property p_lockHold;
    (lock_reg and s_unlockRun) |-> lock_reg || unlockCnt_reg >= LOCK_CYC - 1;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lock dropped early");

  property p_lockFall;
    $fell(lock_reg) |-> $past(unlockCnt_reg) == LOCK_CYC - 1 && !$past(synthLocked);
  endproperty
  a_lockFall: assert property (p_lockFall) else $error("lock fall without filter");

  property p_ptt;
    |(pttSrc & pttMask_reg) |=> pttRefl_reg;
  endproperty
  a_ptt: assert property (p_ptt) else $error("reflected ptt missing");

  property p_ctrlLatch;
    !ctrlSet[0] && !ctrlClr[0] |=> ctrlSt_reg[0] == $past(ctrlSt_reg[0]);
  endproperty
  a_ctrlLatch: assert property (p_ctrlLatch) else $error("control line not latched");
endmodule

// ---- hdl/status_out_defines.svh ----
`ifndef STATUS_OUT_DEFINES_SVH
`define STATUS_OUT_DEFINES_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_LINES 8'h04
`define REG_PTTMASK 8'h08
`define REG_ALERTCFG 8'h0C
`define REG_CALLMAP 8'h10
`define REG_STATUS 8'h14
`define REG_INTSTAT 8'h18
`define REG_INTMASK 8'h1C
// control fields
`define CTRL_NOISE 0
`define CTRL_FKLATCH 1
`define CTRL_FLASH1 2
`define CTRL_FLASH2 3
// line config: select in low four bits, polarity above
`define LINE_W 5
`define LINE_POL 4
`define NUM_LINES 4
// signal select codes
`define SIG_NONE 4'h0
`define SIG_BUSY 4'h1
`define SIG_TX 4'h2
`define SIG_LOCK 4'h3
`define SIG_PTT 4'h4
`define SIG_ALERT1 4'h5
`define SIG_ALERT2 4'h6
`define SIG_CTRL1 4'h7
`define SIG_FKEY 4'hA
`define STATUS_READY 11
// reset values
`define CTRL_RST 32'h0000_0000
`define LINES_RST 20'h0_0000
// timing
`define CLK_KHZ 200000
`define LOCK_FILTER_MS 50
`define POWERUP_MS 2000
`define TICK_MS 1
`define FLASH_MS 250
`define LOCK_FILTER_CYC (`LOCK_FILTER_MS * `CLK_KHZ)
`define POWERUP_CYC (`POWERUP_MS * `CLK_KHZ)
`define TICK_CYC (`TICK_MS * `CLK_KHZ)
`endif

// ---- hdl/status_out_pkg.sv ----
package status_out_pkg;
  // external alert sequencer states
  typedef enum logic [1:0] {ALERT_IDLE, ALERT_WAIT, ALERT_ON} alert_state_type;
  typedef logic [3:0] sig_sel_type;
endpackage

// ---- verif/ext_circuit.sv ----
////////////////////////////////////////////////////////////////////////
// attached application circuit: weak pull-ups on every line, reads low as active
module ext_circuit (
  input wire logic [3:0] lineOut,
  input wire logic [3:0] lineOe,
  output logic [3:0] pinLevel,
  output logic [3:0] sensedActive
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line floats up to the pull-up level
  assign pinLevel = (lineOut & lineOe) | ~lineOe;
  // low-active reading so the undriven power-up state looks inactive
  assign sensedActive = ~pinLevel;
endmodule

// ---- verif/testbench.sv ----
`include "status_out_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PWR = 20;
  localparam int unsigned LCK = 16;
  localparam int unsigned TCK = 4;
  typedef struct {
    logic [31:0] ctrl;
    logic rssi;
    logic noise;
    logic tx;
    logic inh;
    logic [7:0] ptt;
    logic [3:0] expLine;
    logic expRf;
  } row_type;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, rfOutEnable;
  logic [7:0] paddr, pttSrc;
  logic [31:0] pwdata, prdata, rdVal;
  logic rssiDetect, noiseDetect, txActive, rfInhibit, synthLocked, callStart, fkeyPress;
  logic [1:0] callKind;
  logic [2:0] ctrlSet, ctrlClr;
  logic [3:0] lineOut, lineOe, pinLevel, sensedActive;
  logic errFlag;
  int errorCnt, checked;
  row_type rows [8];

  ////////////////////////////////////////////////////////////////////////
  programmable_status_outputs #(.LOCK_CYC(LCK), .POWERUP_CYC(PWR), .TICK_CYC(TCK))
    programmable_status_outputs_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rssiDetect(rssiDetect), .noiseDetect(noiseDetect),
    .txActive(txActive), .rfInhibit(rfInhibit), .synthLocked(synthLocked), .pttSrc(pttSrc),
    .callStart(callStart), .callKind(callKind), .ctrlSet(ctrlSet), .ctrlClr(ctrlClr),
    .fkeyPress(fkeyPress), .rfOutEnable(rfOutEnable), .lineOut(lineOut), .lineOe(lineOe),
    .irq(irq));
  ext_circuit ext_circuit_inst (.lineOut(lineOut), .lineOe(lineOe), .pinLevel(pinLevel),
    .sensedActive(sensedActive));

  // clock at 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("errors %0d checks %0d", errorCnt, checked);
    if (errorCnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one apb transfer; returns after the release edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50) begin
      errorCnt++;
      $display("MISMATCH %0t bus answer timed out", $time);
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd, rdVal, errFlag);
  endtask

  // reset, then lines must stay released for the power-up hold
  task automatic powerup;
    int n;
    rst <= 1'b1;
    cyc(2);
    cmp(lineOe, 4'h0, "oe in reset");
    cyc(18);
    rst <= 1'b0;
    cyc(PWR - 1);
    cmp(lineOe, 4'h0, "oe in hold");
    cmp(sensedActive, 4'h0, "pulled-up inactive");
    n = 0;
    while (lineOe !== 4'hF && n < 10) begin
      cyc(1);
      n++;
    end
    cmp(lineOe, 4'hF, "oe after hold");
    if (lineOe !== 4'hF) close_out();
  endtask

  task automatic pulse_call(input logic [1:0] kind);
    callKind <= kind;
    callStart <= 1'b1;
    cyc(1);
    callStart <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rssiDetect, noiseDetect} = '0;
    {txActive, rfInhibit, pttSrc, callStart, callKind, ctrlSet, ctrlClr, fkeyPress} = '0;
    synthLocked = 1'b1;
    rst = 1'b1;
    errorCnt = 0;
    checked = 0;
    rows[0] = '{32'h0, 0, 0, 0, 0, 8'h00, 4'h2, 0};
    rows[1] = '{32'h0, 1, 0, 0, 0, 8'h00, 4'h3, 0};
    rows[2] = '{32'h1, 1, 0, 0, 0, 8'h00, 4'h2, 0};
    rows[3] = '{32'h1, 0, 1, 0, 0, 8'h00, 4'h3, 0};
    rows[4] = '{32'h0, 0, 0, 1, 0, 8'h02, 4'h4, 1};
    rows[5] = '{32'h0, 0, 0, 1, 1, 8'h01, 4'h0, 0};
    rows[6] = '{32'h0, 1, 0, 0, 0, 8'h08, 4'h7, 0};
    rows[7] = '{32'h0, 0, 0, 0, 0, 8'hF5, 4'h2, 0};
    powerup();
    // reset values, unmapped place, read-only status
    apb(1'b0, `REG_CTRL, 32'h0, rdVal, errFlag);
    cmp(rdVal, `CTRL_RST, "ctrl reset");
    apb(1'b0, `REG_LINES, 32'h0, rdVal, errFlag);
    cmp(rdVal, 32'h0, "lines reset");
    apb(1'b0, 8'h20, 32'h0, rdVal, errFlag);
    cmp({rdVal[30:0], errFlag}, 32'h1, "unmapped read");
    wr(`REG_STATUS, 32'h0);
    apb(1'b0, `REG_STATUS, 32'h0, rdVal, errFlag);
    cmp(rdVal[`STATUS_READY], 1'b1, "ready bit");
    // busy, tx, ptt, unused lines with mixed polarity
    wr(`REG_LINES, 32'h0008_5051);
    wr(`REG_PTTMASK, 32'h0000_000A);
    foreach (rows[i]) begin
      wr(`REG_CTRL, rows[i].ctrl);
      rssiDetect <= rows[i].rssi;
      noiseDetect <= rows[i].noise;
      txActive <= rows[i].tx;
      rfInhibit <= rows[i].inh;
      pttSrc <= rows[i].ptt;
      cyc(3);
      cmp(lineOut, rows[i].expLine, "row lines");
      cmp(rfOutEnable, rows[i].expRf, "row rf");
    end
    {rssiDetect, noiseDetect, txActive, rfInhibit, pttSrc} <= '0;
    wr(`REG_CTRL, 32'h0);
    // short unlock filtered, long unlock drops the lock line
    wr(`REG_LINES, 32'h0009_D051);
    cyc(1);
    cmp(lineOut[3], 1'b1, "locked");
    synthLocked <= 1'b0;
    repeat (12) begin
      cyc(1);
      cmp(lineOut[3], 1'b1, "brief unlock");
    end
    synthLocked <= 1'b1;
    cyc(3);
    synthLocked <= 1'b0;
    cyc(LCK - 2);
    cmp(lineOut[3], 1'b1, "unlock below limit");
    cyc(6);
    cmp(lineOut[3], 1'b0, "unlock past limit");
    synthLocked <= 1'b1;
    // sticky events, mask, write-one clear
    apb(1'b0, `REG_INTSTAT, 32'h0, rdVal, errFlag);
    cmp(rdVal, 32'h3, "event bits");
    cmp(irq, 1'b0, "masked irq");
    wr(`REG_INTMASK, 32'h2);
    cmp(irq, 1'b1, "unmasked irq");
    wr(`REG_INTSTAT, 32'h1);
    cmp(irq, 1'b1, "other bit cleared");
    wr(`REG_INTSTAT, 32'h2);
    cmp(irq, 1'b0, "irq cleared");
    apb(1'b0, `REG_INTSTAT, 32'h0, rdVal, errFlag);
    cmp(rdVal, 32'h0, "events cleared");
    // control lines latch, key momentary then latching
    wr(`REG_LINES, 32'h0000_6B37);
    ctrlSet <= 3'b101;
    cyc(1);
    ctrlSet <= 3'b000;
    cyc(8);
    cmp(lineOut, 4'hB, "ctrl latched");
    fkeyPress <= 1'b1;
    cyc(3);
    cmp(lineOut, 4'hF, "key pressed");
    fkeyPress <= 1'b0;
    cyc(3);
    cmp(lineOut, 4'hB, "key momentary");
    ctrlClr <= 3'b001;
    cyc(1);
    ctrlClr <= 3'b000;
    cyc(3);
    cmp(lineOut, 4'hA, "ctrl cleared");
    wr(`REG_CTRL, 32'h2);
    fkeyPress <= 1'b1;
    cyc(3);
    fkeyPress <= 1'b0;
    cyc(3);
    cmp(lineOut, 4'hE, "key latched");
    wr(`REG_CTRL, 32'h0);
    // every call kind, each with its own alert selection
    wr(`REG_LINES, 32'h0000_02D5);
    wr(`REG_ALERTCFG, 32'h0002_0002);
    wr(`REG_CALLMAP, 32'h0000_008D);
    for (int k = 0; k < 4; k++) begin
      pulse_call(k[1:0]);
      cyc(2);
      cmp(lineOut[1:0], 2'b00, "alert before delay");
      cyc(20);
      cmp(lineOut[1:0], 2'((8'h8D >> (2 * k)) & 8'h03), "alert on");
      pttSrc <= 8'h01;
      cyc(3);
      cmp(lineOut[1:0], 2'b00, "alert answered");
      pttSrc <= 8'h00;
      cyc(2);
    end
    // flashing alert 1 with no end, alert 2 for a fixed three ms
    wr(`REG_CTRL, 32'h4);
    wr(`REG_ALERTCFG, 32'h0300_0000);
    pulse_call(2'd1);
    cyc(4);
    cmp(lineOut[1:0], 2'b11, "both alerts on");
    cyc(25);
    cmp(lineOut[1:0], 2'b01, "alert 2 duration over");
    cyc(1070);
    cmp(lineOut[1:0], 2'b00, "alert 1 flash off phase");
    cyc(1000);
    cmp(lineOut[1:0], 2'b01, "alert 1 flash on phase");
    pttSrc <= 8'h02;
    cyc(3);
    cmp(lineOut[1:0], 2'b00, "flashing alert answered");
    pttSrc <= 8'h00;
    // reset again in mid-run, control left non-default on purpose
    powerup();
    apb(1'b0, `REG_CTRL, 32'h0, rdVal, errFlag);
    cmp(rdVal, `CTRL_RST, "ctrl after mid-run reset");
    close_out();
  end
endmodule
